// *** pkg/i2csr_pkg.sv ***
`default_nettype none
package i2csr_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    // Length of the line disturbance produced when the module is switched on.
    localparam int ENABLE_GLITCH_NS = 400;
    localparam logic [2:0] GLITCH_CYCLES =
        3'((ENABLE_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // Byte framing and addressing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_HELD = 4'h9;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
    localparam logic [3:0] RES_NIBBLE_LO = 4'h0;
    localparam logic [3:0] RES_NIBBLE_HI = 4'hf;
    localparam logic [9:0] QUIRK_ADDR = 10'h102;
    localparam logic [7:0] QUIRK_LOWER = 8'h01;
    localparam logic [1:0] IDX_FIRST = 2'h0;
    localparam logic [1:0] IDX_LOWER = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RECV = 3'h1,
        ST_ACK = 3'h3,
        ST_SEND = 3'h2,
        ST_MACK = 3'h6
    } i2csr_state_type;

    typedef struct packed {
        logic rx_buffer_full;
        logic rx_overflow_flag;
        logic slave_event_flag;
        logic data_not_address;
        logic start_seen;
        logic stop_seen;
    } i2csr_status_type;

    typedef struct packed {
        logic sda_oe_n;
        logic sda_out;
        logic scl_oe_n;
        logic scl_out;
    } i2csr_pins_type;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_d;
        logic sda_s1;
        logic sda_s2;
        logic sda_d;
        logic en_d;
        logic [2:0] glitch_cnt;
        i2csr_state_type st;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic [1:0] byte_idx;
        logic addressed;
        logic reading;
        logic ack_pend;
        logic macked;
        logic sda_drv;
        logic [7:0] rx_hold;
        i2csr_status_type stat;
        i2csr_pins_type pins;
    } i2csr_regs_type;
endpackage
`default_nettype wire

// *** core/i2csr_core.sv ***
// Notes on behaviour
// - Every received byte loads the holding register except a reserved ten-bit lower byte, other than the matching one of address 0x102.
// - Byte into full buffer sets overflow flag.
// - Overflow blocks slave event on data byte.
// - Holding register read clears buffer-full flag.
// - Own address match always sets slave event.
// - Flag tells address byte from data byte.
// - Address flag with overflow only after match.
// - Newest data byte kept, older unread lost.
// - Shared upper bits: ack and drive read data.
// - Reserved ten-bit lower bytes are not loaded, except the matching one of address 0x102.
// - Address 0x102 stores lower byte as 0x01.
// - Enabling drives both lines low briefly.
// - Enable sets start seen, clears stop seen.
// - Higher precedence peripheral overrides pin drive.
`timescale 1ns/10ps
`default_nettype none
module i2csr_core (
    input wire logic clk,
    input wire logic srst,
    input wire logic scl_in,
    input wire logic sda_in,
    output i2csr_pkg::i2csr_pins_type pins,
    input wire logic bus_module_enable,
    input wire logic ten_bit_mode,
    input wire logic [9:0] own_addr,
    input wire logic [7:0] tx_data,
    input wire logic rx_read,
    input wire logic ovf_clear,
    input wire logic slave_event_clear,
    input wire logic periph_override,
    input wire logic periph_sda_out,
    input wire logic periph_scl_out,
    output logic [7:0] rx_holding_register,
    output i2csr_pkg::i2csr_status_type status
);
    import i2csr_pkg::*;

    i2csr_regs_type r_ff;
    i2csr_regs_type nxt_r;
    logic [7:0] byte_in;
    logic scl_rise, scl_fall, start_ev, stop_ev, en_rise;
    logic upper_ok, lower_res, load_now, addr_hit, data_hit, res_skip, ack;

    // ==========================================================
    // Next state
    always_comb begin
        nxt_r = r_ff;
        byte_in = {r_ff.shreg[6:0], r_ff.sda_s2};
        load_now = 1'b0;
        addr_hit = 1'b0;
        data_hit = 1'b0;
        res_skip = 1'b0;
        ack = 1'b0;
        scl_rise = r_ff.scl_s2 & ~r_ff.scl_d;
        scl_fall = ~r_ff.scl_s2 & r_ff.scl_d;
        start_ev = r_ff.scl_s2 & r_ff.scl_d & r_ff.sda_d & ~r_ff.sda_s2;
        stop_ev = r_ff.scl_s2 & r_ff.scl_d & ~r_ff.sda_d & r_ff.sda_s2;
        en_rise = bus_module_enable & ~r_ff.en_d;
        upper_ok = (byte_in[7:3] == TEN_BIT_PREFIX) && (byte_in[2:1] == own_addr[9:8]);
        lower_res = ((byte_in[7:4] == RES_NIBBLE_LO) || (byte_in[7:4] == RES_NIBBLE_HI))
            && !upper_ok;
        nxt_r.scl_s1 = scl_in;
        nxt_r.scl_s2 = r_ff.scl_s1;
        nxt_r.scl_d = r_ff.scl_s2;
        nxt_r.sda_s1 = sda_in;
        nxt_r.sda_s2 = r_ff.sda_s1;
        nxt_r.sda_d = r_ff.sda_s2;
        nxt_r.en_d = bus_module_enable;
        if (!bus_module_enable) begin
            nxt_r.st = ST_IDLE;
            nxt_r.addressed = 1'b0;
            nxt_r.sda_drv = 1'b0;
        end else if (start_ev) begin
            nxt_r.st = ST_RECV;
            nxt_r.bitcnt = 4'h0;
            nxt_r.byte_idx = IDX_FIRST;
            nxt_r.addressed = 1'b0;
            nxt_r.reading = 1'b0;
            nxt_r.sda_drv = 1'b0;
            nxt_r.stat.start_seen = 1'b1;
            nxt_r.stat.stop_seen = 1'b0;
        end else if (stop_ev) begin
            nxt_r.st = ST_IDLE;
            nxt_r.addressed = 1'b0;
            nxt_r.sda_drv = 1'b0;
            nxt_r.stat.start_seen = 1'b0;
            nxt_r.stat.stop_seen = 1'b1;
        end else begin
            unique case (r_ff.st)
                ST_IDLE: begin
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        nxt_r.shreg = byte_in;
                        nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                        if (r_ff.bitcnt == BITS_PER_BYTE - 4'h1) begin
                            nxt_r.st = ST_ACK;
                            nxt_r.byte_idx = IDX_DATA;
                            if (r_ff.byte_idx == IDX_FIRST) begin
                                load_now = 1'b1;
                                if (ten_bit_mode) begin
                                    // Only the two upper bits are compared here, so a
                                    // master with the same upper bits is answered too.
                                    ack = upper_ok;
                                    addr_hit = upper_ok & byte_in[0];
                                    if (upper_ok && !byte_in[0]) begin
                                        nxt_r.byte_idx = IDX_LOWER;
                                    end
                                end else begin
                                    addr_hit = (byte_in[7:1] == own_addr[6:0]);
                                end
                                nxt_r.reading = addr_hit & byte_in[0];
                            end else if (r_ff.byte_idx == IDX_LOWER) begin
                                addr_hit = (byte_in == own_addr[7:0]);
                                // The odd address below is stored although its lower
                                // byte falls in the reserved range.
                                res_skip = lower_res
                                    && !(addr_hit && own_addr == QUIRK_ADDR);
                                load_now = !res_skip;
                            end else begin
                                load_now = 1'b1;
                                data_hit = r_ff.addressed & ~r_ff.reading;
                            end
                            nxt_r.ack_pend = ack | addr_hit | data_hit;
                            if (addr_hit) begin
                                nxt_r.addressed = 1'b1;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (r_ff.bitcnt == BITS_PER_BYTE) begin
                            nxt_r.sda_drv = r_ff.ack_pend;
                            nxt_r.bitcnt = ACK_HELD;
                        end else if (r_ff.reading && r_ff.ack_pend) begin
                            nxt_r.st = ST_SEND;
                            nxt_r.shreg = tx_data;
                            nxt_r.sda_drv = ~tx_data[7];
                            nxt_r.bitcnt = 4'h0;
                        end else begin
                            nxt_r.st = ST_RECV;
                            nxt_r.sda_drv = 1'b0;
                            nxt_r.bitcnt = 4'h0;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        if (r_ff.bitcnt == BITS_PER_BYTE - 4'h1) begin
                            nxt_r.st = ST_MACK;
                            nxt_r.sda_drv = 1'b0;
                            nxt_r.macked = 1'b0;
                        end else begin
                            nxt_r.shreg = {r_ff.shreg[6:0], 1'b0};
                            nxt_r.sda_drv = ~r_ff.shreg[6];
                            nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (r_ff.sda_s2) begin
                            nxt_r.st = ST_IDLE;
                        end else begin
                            nxt_r.macked = 1'b1;
                        end
                    end else if (scl_fall && r_ff.macked) begin
                        nxt_r.st = ST_SEND;
                        nxt_r.shreg = tx_data;
                        nxt_r.sda_drv = ~tx_data[7];
                        nxt_r.bitcnt = 4'h0;
                    end
                end
            endcase
        end
        // Software clears first so that a hardware set in the same cycle wins.
        if (rx_read) begin
            nxt_r.stat.rx_buffer_full = 1'b0;
        end
        if (ovf_clear) begin
            nxt_r.stat.rx_overflow_flag = 1'b0;
        end
        if (slave_event_clear) begin
            nxt_r.stat.slave_event_flag = 1'b0;
        end
        if (load_now) begin
            if (r_ff.stat.rx_buffer_full && !rx_read) begin
                nxt_r.stat.rx_overflow_flag = 1'b1;
            end
            nxt_r.stat.rx_buffer_full = 1'b1;
            // The holding register is overwritten even on overflow.
            nxt_r.rx_hold = byte_in;
            if (addr_hit && r_ff.byte_idx == IDX_LOWER && own_addr == QUIRK_ADDR) begin
                nxt_r.rx_hold = QUIRK_LOWER;
            end
        end
        if (addr_hit) begin
            nxt_r.stat.slave_event_flag = 1'b1;
            nxt_r.stat.data_not_address = 1'b0;
        end
        if (data_hit) begin
            nxt_r.stat.data_not_address = 1'b1;
            // The byte that overflows the buffer is held back from software as well.
            if (!r_ff.stat.rx_overflow_flag && !nxt_r.stat.rx_overflow_flag) begin
                nxt_r.stat.slave_event_flag = 1'b1;
            end
        end
        if (r_ff.glitch_cnt != 3'h0) begin
            nxt_r.glitch_cnt = r_ff.glitch_cnt - 3'h1;
        end
        if (en_rise) begin
            nxt_r.glitch_cnt = GLITCH_CYCLES;
            nxt_r.stat.start_seen = 1'b1;
            nxt_r.stat.stop_seen = 1'b0;
        end
        if (periph_override) begin
            nxt_r.pins = '{sda_oe_n: 1'b0, sda_out: periph_sda_out,
                           scl_oe_n: 1'b0, scl_out: periph_scl_out};
        end else if (nxt_r.glitch_cnt != 3'h0) begin
            nxt_r.pins = '{sda_oe_n: 1'b0, sda_out: 1'b0,
                           scl_oe_n: 1'b0, scl_out: 1'b0};
        end else begin
            nxt_r.pins = '{sda_oe_n: ~nxt_r.sda_drv, sda_out: 1'b0,
                           scl_oe_n: 1'b1, scl_out: 1'b0};
        end
        if (srst) begin
            nxt_r = '0;
            nxt_r.scl_s1 = 1'b1;
            nxt_r.scl_s2 = 1'b1;
            nxt_r.scl_d = 1'b1;
            nxt_r.sda_s1 = 1'b1;
            nxt_r.sda_s2 = 1'b1;
            nxt_r.sda_d = 1'b1;
            nxt_r.pins = '{sda_oe_n: 1'b1, sda_out: 1'b0, scl_oe_n: 1'b1, scl_out: 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        r_ff <= nxt_r;
    end

    assign pins = r_ff.pins;
    assign status = r_ff.stat;
    assign rx_holding_register = r_ff.rx_hold;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence glitch_run_s;
        (r_ff.glitch_cnt != 3'h0) [*4] ##1 (r_ff.glitch_cnt == 3'h0);
    endsequence

    load_marks_full_a: assert property (load_now |=> r_ff.stat.rx_buffer_full)
        else $error("loaded byte did not mark buffer full");
    overflow_set_a: assert property (
        load_now && r_ff.stat.rx_buffer_full && !rx_read |=> r_ff.stat.rx_overflow_flag)
        else $error("byte into full buffer did not flag overflow");
    ovf_blocks_event_a: assert property (
        data_hit && (r_ff.stat.rx_overflow_flag || (r_ff.stat.rx_buffer_full && !rx_read))
        && !r_ff.stat.slave_event_flag |=> !r_ff.stat.slave_event_flag)
        else $error("slave event raised during overflow");
    read_clears_full_a: assert property (
        rx_read && !load_now |=> !r_ff.stat.rx_buffer_full)
        else $error("read did not clear buffer full");
    match_sets_event_a: assert property (
        addr_hit |=> r_ff.stat.slave_event_flag && !r_ff.stat.data_not_address)
        else $error("address match did not raise slave event");
    data_flag_a: assert property (data_hit |=> r_ff.stat.data_not_address)
        else $error("data byte not marked as data");
    keeps_newest_a: assert property (
        load_now && !(addr_hit && r_ff.byte_idx == IDX_LOWER && own_addr == QUIRK_ADDR)
        |=> r_ff.rx_hold == $past(byte_in))
        else $error("newest received byte not kept");
    read_drive_a: assert property (
        r_ff.st == ST_SEND && r_ff.glitch_cnt == 3'h0 && !$past(periph_override)
        |-> pins.sda_oe_n == !r_ff.sda_drv)
        else $error("read data not driven on the data line");
    reserved_skip_a: assert property (res_skip |=> $stable(r_ff.rx_hold))
        else $error("reserved lower address byte was loaded");
    quirk_lower_a: assert property (
        load_now && addr_hit && r_ff.byte_idx == IDX_LOWER && own_addr == QUIRK_ADDR
        |=> r_ff.rx_hold == QUIRK_LOWER)
        else $error("odd address stored the wrong lower byte");
    enable_glitch_a: assert property (en_rise |=> glitch_run_s)
        else $error("enable glitch has wrong length");
    glitch_pins_a: assert property (
        r_ff.glitch_cnt != 3'h0 && !$past(periph_override)
        |-> !pins.sda_oe_n && !pins.scl_oe_n)
        else $error("lines not pulled low during enable glitch");
    enable_status_a: assert property (
        en_rise && !srst |=> r_ff.stat.start_seen && !r_ff.stat.stop_seen)
        else $error("enable did not show start condition");
    override_pins_a: assert property (
        periph_override |=> !pins.sda_oe_n && pins.sda_out == $past(periph_sda_out))
        else $error("peripheral override not applied");
    // Reset is checked under its own disable, since the default one would hide it.
    reset_clears_a: assert property (disable iff (1'b0)
        srst |=> status == '0 && rx_holding_register == 8'h00)
        else $error("reset did not clear flags and holding register");
endmodule
`default_nettype wire

// *** dv/i2csr_bus_master.sv ***
`timescale 1ns/10ps
`default_nettype none
// ========
// Bus master on the far side of the two-wire link.
module i2csr_bus_master (
    output logic scl_drv,
    output logic sda_drv,
    input wire logic sda_line
);
    // A 1 releases the line to its pull-up; the clock stands still between frames.
    // Nothing is started until the bench asks, so the module can finish initialising.
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic start_cond();
        sda_drv = 1'b1;
        #250 scl_drv = 1'b1;
        #250 sda_drv = 1'b0;
        #250 scl_drv = 1'b0;
    endtask

    // Data changes well inside the low phase so the slave's synchronisers see it settled.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #250 sda_drv = b[i];
            #250 scl_drv = 1'b1;
            #300 scl_drv = 1'b0;
        end
        #250 sda_drv = 1'b1;
        #250 scl_drv = 1'b1;
        #150 ack = sda_line;
        #150 scl_drv = 1'b0;
    endtask

    // Drives its own byte while reading, so a second transmitter shows as the wired-AND.
    task automatic recv_byte(input logic [7:0] mine, input logic nack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #250 sda_drv = mine[i];
            #250 scl_drv = 1'b1;
            #150 b[i] = sda_line;
            #150 scl_drv = 1'b0;
        end
        #250 sda_drv = nack;
        #250 scl_drv = 1'b1;
        #300 scl_drv = 1'b0;
    endtask

    task automatic stop_cond();
        #250 sda_drv = 1'b0;
        #250 scl_drv = 1'b1;
        #250 sda_drv = 1'b1;
        #250;
    endtask
endmodule
`default_nettype wire

// *** dv/i2csr_core_test.sv ***
`timescale 1ns/10ps
`default_nettype none
// ========
// Self-checking bench.
module i2csr_core_test;
    import i2csr_pkg::*;
    typedef struct {string name; int sel; logic [7:0] exp;} i2csr_note_type;
    logic clk, srst, bus_module_enable, ten_bit_mode, rx_read, ovf_clear, slave_event_clear;
    logic periph_override, periph_sda_out, periph_scl_out, scl_drv, sda_drv, ack;
    logic scl_line, sda_line;
    logic [9:0] own_addr;
    logic [7:0] tx_data, rx_holding_register, d1, d2, d3, fa, rd, mn;
    i2csr_pins_type pins;
    i2csr_status_type status;
    int num_errors = 0;
    int samples_checked = 0;
    int cycle_count = 0;
    i2csr_note_type exp_q[$];
    event check_ev;

    // Wired-AND of all open-drain drivers; released lines float up to the pull-up.
    assign scl_line = scl_drv & (pins.scl_oe_n | pins.scl_out);
    assign sda_line = sda_drv & (pins.sda_oe_n | pins.sda_out);

    i2csr_core i2csr_core_inst (.clk(clk), .srst(srst), .scl_in(scl_line), .sda_in(sda_line),
        .pins(pins), .bus_module_enable(bus_module_enable), .ten_bit_mode(ten_bit_mode),
        .own_addr(own_addr), .tx_data(tx_data), .rx_read(rx_read), .ovf_clear(ovf_clear),
        .slave_event_clear(slave_event_clear), .periph_override(periph_override),
        .periph_sda_out(periph_sda_out), .periph_scl_out(periph_scl_out),
        .rx_holding_register(rx_holding_register), .status(status));
    i2csr_bus_master i2csr_bus_master_inst (.scl_drv(scl_drv), .sda_drv(sda_drv),
        .sda_line(sda_line));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [7:0] pick(int sel);
        case (sel)
            0: return rx_holding_register;
            1: return {4'h0, status[5:2]};
            2: return {6'h00, status[1:0]};
            3: return {7'h00, ack};
            4: return {4'h0, pins};
            6: return rd;
            default: return {7'h00, status.rx_buffer_full};
        endcase
    endfunction

    task automatic note(string name, int sel, logic [7:0] exp);
        @(negedge clk);
        exp_q.push_back('{name, sel, exp});
        -> check_ev;
    endtask

    initial begin
        i2csr_note_type n;
        forever begin
            @(check_ev);
            while (exp_q.size() > 0) begin
                n = exp_q.pop_front();
                samples_checked++;
                if (pick(n.sel) !== n.exp) begin
                    num_errors++;
                    $display("BAD %s expected %h seen %h", n.name, n.exp, pick(n.sel));
                end
            end
        end
    end

    task automatic sw(logic r, logic o, logic s);
        @(negedge clk);
        rx_read = r;
        ovf_clear = o;
        slave_event_clear = s;
        @(negedge clk);
        rx_read = 1'b0;
        ovf_clear = 1'b0;
        slave_event_clear = 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Under a thousand cycles cover every frame; reaching the ceiling of 6000 means a hang.
    always @(posedge clk) begin
        cycle_count++;
        if (cycle_count == 6000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(42923));
        srst = 1'b1;
        {bus_module_enable, ten_bit_mode, rx_read, ovf_clear, slave_event_clear} = 5'h00;
        {periph_override, periph_sda_out, periph_scl_out} = 3'h0;
        own_addr = 10'h05a;
        tx_data = 8'($urandom());
        d1 = 8'($urandom());
        d2 = 8'($urandom());
        d3 = 8'($urandom());
        fa = {7'h5a ^ (7'($urandom()) | 7'h01), 1'b0};
        repeat (4) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        note("holding", 0, 8'h00);
        note("flags", 1, 8'h00);
        periph_override = 1'b1;
        {periph_sda_out, periph_scl_out} = 2'h3;
        bus_module_enable = 1'b1;
        note("pins", 4, 8'h05);
        repeat (8) @(negedge clk);
        note("pins", 4, 8'h05);
        bus_module_enable = 1'b0;
        periph_override = 1'b0;
        repeat (8) @(negedge clk);
        bus_module_enable = 1'b1;
        note("pins", 4, 8'h00);
        note("startstop", 2, 8'h02);
        repeat (16) @(negedge clk);
        i2csr_bus_master_inst.start_cond();
        i2csr_bus_master_inst.send_byte(fa, ack);
        i2csr_bus_master_inst.send_byte(d1, ack);
        i2csr_bus_master_inst.stop_cond();
        note("holding", 0, d1);
        note("flags", 1, 8'h0c);
        i2csr_bus_master_inst.start_cond();
        i2csr_bus_master_inst.send_byte(8'hb4, ack);
        note("ack", 3, 8'h00);
        note("holding", 0, 8'hb4);
        note("flags", 1, 8'h0e);
        sw(1'b1, 1'b1, 1'b1);
        note("flags", 1, 8'h00);
        i2csr_bus_master_inst.send_byte(d2, ack);
        note("holding", 0, d2);
        note("flags", 1, 8'h0b);
        sw(1'b0, 1'b0, 1'b1);
        i2csr_bus_master_inst.send_byte(d3, ack);
        note("holding", 0, d3);
        note("flags", 1, 8'h0d);
        i2csr_bus_master_inst.stop_cond();
        sw(1'b1, 1'b1, 1'b1);
        ten_bit_mode = 1'b1;
        own_addr = 10'h102;
        i2csr_bus_master_inst.start_cond();
        i2csr_bus_master_inst.send_byte(8'hf2, ack);
        note("ack", 3, 8'h00);
        i2csr_bus_master_inst.send_byte(8'h02, ack);
        note("ack", 3, 8'h00);
        note("holding", 0, 8'h01);
        i2csr_bus_master_inst.stop_cond();
        own_addr = 10'h105;
        i2csr_bus_master_inst.start_cond();
        i2csr_bus_master_inst.send_byte(8'hf2, ack);
        sw(1'b1, 1'b0, 1'b0);
        i2csr_bus_master_inst.send_byte(8'h05, ack);
        note("holding", 0, 8'hf2);
        note("full", 5, 8'h00);
        i2csr_bus_master_inst.stop_cond();
        mn = 8'($urandom());
        i2csr_bus_master_inst.start_cond();
        i2csr_bus_master_inst.send_byte(8'hf3, ack);
        note("ack", 3, 8'h00);
        i2csr_bus_master_inst.recv_byte(mn, 1'b1, rd);
        note("read", 6, mn & tx_data);
        i2csr_bus_master_inst.stop_cond();
        tally_and_finish();
    end
endmodule
`default_nettype wire
